/* File: verilog/rlcb_top.sv */
/*
 * rlcb_top: sixteen remote control switches and sixteen latch control switches,
 * both updated once per processing interval (the latch bank also on a restore), with edge operators on each bank.
 * Assumes commands and latch conditions come from logic on mclk_in, and that
 * a nonvolatile store outside keeps latch states and replays them after reset.
 */
`timescale 1ns/1ps
module rlcb_top
    import rlcb_pkg::*;
#(
    parameter int unsigned DIV_CYC = INTERVAL_CYC           // clocks per interval
)
(
    input  wire logic                mclk_in,                // 100 MHz core clock
    input  wire logic                rst_n_in,               // sync reset, active low
    // remote control commands from the port handler
    input  wire logic                remote_control_command_in,  // command strobe
    input  wire logic [1:0]          cmd_op_in,              // rlcb_op_t code
    input  wire logic [IDX_W-1:0]    cmd_index_in,           // remote bit number
    // latch conditions from the control logic
    input  wire logic [NUM_BITS-1:0] latch_set_condition_in,
    input  wire logic [NUM_BITS-1:0] latch_clear_condition_in,
    input  wire logic [NUM_BITS-1:0] latch_toggle_in,        // each rising edge seen at a tick toggles
    // replay of stored latch states after power-up
    input  wire logic                nv_restore_valid_in,
    input  wire logic [NUM_BITS-1:0] nv_restore_data_in,
    // outputs, all registered
    output logic [NUM_BITS-1:0]      remote_switch_bit_out,
    output logic [NUM_BITS-1:0]      remote_rise_out,
    output logic [NUM_BITS-1:0]      remote_fall_out,
    output logic [NUM_BITS-1:0]      latching_switch_bit_out,
    output logic [NUM_BITS-1:0]      latch_rise_out,
    output logic [NUM_BITS-1:0]      latch_fall_out,
    output logic                     latch_changed_out,      // store request pulse
    output logic [NUM_BITS-1:0]      latch_state_out,        // value to store
    output logic                     interval_tick_out       // interval boundary
);

    // ------------------------------------------------------------------
    // interval timebase
    // ------------------------------------------------------------------

    logic tick;                                              // one cycle per interval

    // one enable pulse per quarter power cycle drives the switch and edge updates below; command capture and restore do not wait for it
    rlcb_tick_div #(
        .DIV_CYC (DIV_CYC)
    ) u_div (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .tick_out (tick)
    );

    // ------------------------------------------------------------------
    // remote switch command capture
    // ------------------------------------------------------------------

    logic [1:0] pend_q [NUM_BITS];                           // command waiting per bit
    logic [1:0] pend_d [NUM_BITS];

    // last command in an interval wins; one arriving on the tick cycle
    // is kept for the next interval rather than dropped
    always_comb
    begin
        for (int i = 0; i < NUM_BITS; i++)
        begin
            pend_d[i] = pend_q[i];
            if (tick)
            begin
                pend_d[i] = RLCB_OP_NONE;                    // consumed this cycle
            end
            if (remote_control_command_in &&
                (cmd_index_in == IDX_W'(i)) &&
                (cmd_op_in != RLCB_OP_NONE))
            begin
                pend_d[i] = cmd_op_in;                       // set beats the clear
            end
        end
    end

    // registers only
    always_ff @(posedge mclk_in)
    begin
        for (int i = 0; i < NUM_BITS; i++)
        begin
            if (!rst_n_in)
            begin
                pend_q[i] <= RLCB_OP_NONE;
            end
            else
            begin
                pend_q[i] <= pend_d[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // remote switch positions
    // ------------------------------------------------------------------

    logic [NUM_BITS-1:0] on_q;                               // switch in ON
    logic [NUM_BITS-1:0] on_d;
    logic [NUM_BITS-1:0] mom_q;                              // switch in MOMENTARY
    logic [NUM_BITS-1:0] mom_d;
    logic [NUM_BITS-1:0] remote_next;                        // bit value next interval

    // positions move only on the tick; momentary always falls back to OFF
    always_comb
    begin
        on_d  = on_q;
        mom_d = mom_q;
        if (tick)
        begin
            for (int i = 0; i < NUM_BITS; i++)
            begin
                mom_d[i] = 1'b0;
                unique case (pend_q[i])
                    RLCB_OP_ON:
                    begin
                        on_d[i] = 1'b1;
                    end
                    RLCB_OP_OFF:
                    begin
                        on_d[i] = 1'b0;
                    end
                    RLCB_OP_PULSE:
                    begin
                        // prior state ignored; ON is dropped so OFF follows
                        on_d[i]  = 1'b0;
                        mom_d[i] = 1'b1;
                    end
                    RLCB_OP_NONE:
                    begin
                        on_d[i] = on_q[i];                   // position held
                    end
                endcase
            end
        end
    end

    assign remote_next = on_d | mom_d;

    // registers only; no settings input exists, so nothing but reset
    // and commands can move a remote bit
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            on_q  <= REMOTE_RST;
            mom_q <= REMOTE_RST;
        end
        else
        begin
            on_q  <= on_d;
            mom_q <= mom_d;
        end
    end

    // remote bits with their edge operators: a pulse from 0 gives a rise
    // now and a fall one interval on; a pulse from 1 gives only a fall
    // because the momentary 1 merely extends the ON level
    rlcb_edge #(
        .W (NUM_BITS)
    ) u_remote_edge (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .en_in    (tick),
        .load_in  (1'b0),
        .val_in   (remote_next),
        .val_out  (remote_switch_bit_out),
        .rise_out (remote_rise_out),
        .fall_out (remote_fall_out)
    );

    // ------------------------------------------------------------------
    // toggle inputs: rising edge sampled once per interval
    // ------------------------------------------------------------------

    logic [NUM_BITS-1:0] tog_rise;                           // new assertion seen

    // limitation: an assertion shorter than one interval may be missed,
    // the same as the edge operator on any other sampled bit
    rlcb_edge #(
        .W (NUM_BITS)
    ) u_toggle_edge (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .en_in    (tick),
        .load_in  (1'b0),
        .val_in   (latch_toggle_in),
        .val_out  (),
        .rise_out (tog_rise),
        .fall_out ()
    );

    // ------------------------------------------------------------------
    // latch switches
    // ------------------------------------------------------------------

    logic [NUM_BITS-1:0] latch_q;                            // latch state
    logic [NUM_BITS-1:0] latch_d;
    logic [NUM_BITS-1:0] set_eff;                            // merged set conditions
    logic [NUM_BITS-1:0] clr_eff;                            // merged clear conditions
    logic                chg_q;                              // store request
    logic                chg_d;

    // toggle path steers one edge to set or clear by the present state,
    // so a long assertion cannot flip the latch twice
    assign set_eff = latch_set_condition_in | (tog_rise & ~latch_q);
    assign clr_eff = latch_clear_condition_in | (tog_rise & latch_q);

    // conditions present on an interval's closing tick act at that tick, so the
    // new value shows in the following interval; restore overrides all
    always_comb
    begin
        latch_d = latch_q;
        chg_d   = 1'b0;
        if (nv_restore_valid_in)
        begin
            latch_d = nv_restore_data_in;
        end
        else if (tick)
        begin
            latch_d = (latch_q | set_eff) & ~clr_eff;
            chg_d   = (latch_d != latch_q);
        end
    end

    // registers only
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            latch_q <= LATCH_RST;
            chg_q   <= 1'b0;
        end
        else
        begin
            latch_q <= latch_d;
            chg_q   <= chg_d;
        end
    end

    // latch bits with edge operators; restore loads silently so a replay
    // after power-up does not look like a fresh set
    rlcb_edge #(
        .W (NUM_BITS)
    ) u_latch_edge (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .en_in    (tick),
        .load_in  (nv_restore_valid_in),
        .val_in   (latch_d),
        .val_out  (latching_switch_bit_out),
        .rise_out (latch_rise_out),
        .fall_out (latch_fall_out)
    );

    // ------------------------------------------------------------------
    // store port and tick
    // ------------------------------------------------------------------

    // writes to the outside store happen only on a real change, which
    // keeps wear on a finite-write memory down
    assign latch_changed_out = chg_q;
    assign latch_state_out   = latch_q;
    assign interval_tick_out = tick;

endmodule : rlcb_top

/* File: verilog/rlcb_pkg.sv */
/*
 * rlcb_pkg: shared constants and types for the remote and latch control bits.
 * Assumes a 100 MHz core clock and a 60 Hz power system.
 */
package rlcb_pkg;

    localparam int unsigned NUM_BITS   = 16;                 // switches per bank
    localparam int unsigned IDX_W      = 4;                  // command index width

    // timing: one processing interval is a quarter power-system cycle
    localparam int unsigned CLK_FREQ_HZ      = 100_000_000;  // mclk_in rate
    localparam int unsigned SYS_FREQ_HZ      = 60;           // power-system frequency
    localparam int unsigned INTERVALS_PER_CY = 4;            // intervals per power cycle
    localparam int unsigned INTERVAL_CYC     =
        CLK_FREQ_HZ / (SYS_FREQ_HZ * INTERVALS_PER_CY);      // clocks per interval
    localparam int unsigned DIV_W            = 20;           // divider counter width

    // reset values
    localparam logic [NUM_BITS-1:0] REMOTE_RST = 16'h0000;   // all OFF at power-up
    localparam logic [NUM_BITS-1:0] LATCH_RST  = 16'h0000;   // before any restore

    // remote switch commands
    typedef enum logic [1:0]
    {
        RLCB_OP_NONE  = 2'h0,
        RLCB_OP_ON    = 2'h1,
        RLCB_OP_OFF   = 2'h2,
        RLCB_OP_PULSE = 2'h3
    } rlcb_op_t;

endpackage : rlcb_pkg

/* File: verilog/rlcb_tick_div.sv */
/*
 * rlcb_tick_div: divides mclk_in down to one enable pulse per processing interval.
 * Assumes a synchronous active-low reset on the same clock.
 */
`timescale 1ns/1ps
module rlcb_tick_div
    import rlcb_pkg::*;
#(
    parameter int unsigned DIV_CYC = INTERVAL_CYC           // clocks per tick
)
(
    input  wire logic mclk_in,                              // core clock
    input  wire logic rst_n_in,                             // sync reset, active low
    output logic      tick_out                              // one-cycle interval tick
);

    localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV_CYC - 1); // terminal count

    logic [DIV_W-1:0] cnt_q;                                 // cycle counter
    logic [DIV_W-1:0] cnt_d;
    logic             tick_q;                                // registered tick
    logic             tick_d;

    // wrap the counter and flag the last cycle
    always_comb
    begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + DIV_W'(1);
        if (cnt_q == LAST)
        begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

endmodule : rlcb_tick_div

/* File: verilog/rlcb_edge.sv */
/*
 * rlcb_edge: per-interval value register with rising and falling edge flags.
 * Assumes en_in is the interval tick and load_in a rare resynchronising load.
 */
`timescale 1ns/1ps
module rlcb_edge
    import rlcb_pkg::*;
#(
    parameter int unsigned W = NUM_BITS                     // bits handled
)
(
    input  wire logic         mclk_in,                      // core clock
    input  wire logic         rst_n_in,                     // sync reset, active low
    input  wire logic         en_in,                        // interval tick
    input  wire logic         load_in,                      // load without edges
    input  wire logic [W-1:0] val_in,                       // value for next interval
    output logic      [W-1:0] val_out,                      // value this interval
    output logic      [W-1:0] rise_out,                     // 0 to 1 this interval
    output logic      [W-1:0] fall_out                      // 1 to 0 this interval
);

    logic [W-1:0] val_q;                                     // current interval value
    logic [W-1:0] val_d;
    logic [W-1:0] rise_q;                                    // edge flags, held a whole interval
    logic [W-1:0] rise_d;
    logic [W-1:0] fall_q;
    logic [W-1:0] fall_d;

    // edges compare new against held value, so they last exactly one interval
    always_comb
    begin
        val_d  = val_q;
        rise_d = rise_q;
        fall_d = fall_q;
        if (load_in)
        begin
            val_d  = val_in;                                 // restore makes no edge
            rise_d = '0;
            fall_d = '0;
        end
        else if (en_in)
        begin
            val_d  = val_in;
            rise_d = val_in & ~val_q;
            fall_d = ~val_in & val_q;
        end
    end

    // registers only
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            val_q  <= '0;
            rise_q <= '0;
            fall_q <= '0;
        end
        else
        begin
            val_q  <= val_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign val_out  = val_q;
    assign rise_out = rise_q;
    assign fall_out = fall_q;

endmodule : rlcb_edge

/* File: verification/rlcb_top_monitor.sv */
/* rlcb_top_monitor: port-level checks of rlcb_top, bound into every instance.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module rlcb_top_monitor
    import rlcb_pkg::*;
#(
    parameter int unsigned DIV_CYC = INTERVAL_CYC           // clocks per interval
)
(
    input wire logic                mclk_in,
    input wire logic                rst_n_in,
    input wire logic [NUM_BITS-1:0] latch_set_condition_in,
    input wire logic [NUM_BITS-1:0] latch_clear_condition_in,
    input wire logic [NUM_BITS-1:0] latch_toggle_in,
    input wire logic                nv_restore_valid_in,
    input wire logic [NUM_BITS-1:0] nv_restore_data_in,
    input wire logic [NUM_BITS-1:0] remote_switch_bit_out,
    input wire logic [NUM_BITS-1:0] remote_rise_out,
    input wire logic [NUM_BITS-1:0] remote_fall_out,
    input wire logic [NUM_BITS-1:0] latching_switch_bit_out,
    input wire logic [NUM_BITS-1:0] latch_rise_out,
    input wire logic                latch_changed_out,
    input wire logic [NUM_BITS-1:0] latch_state_out,
    input wire logic                interval_tick_out
);
    int unsigned gap_d, gap_q;                              // clocks since last tick
    logic        seen_d, seen_q;                            // first tick passed

    // spacing counter; the first gap after reset is not judged
    always_comb
    begin
        gap_d  = interval_tick_out ? 0 : gap_q + 1;
        seen_d = seen_q | interval_tick_out;
    end
    always_ff @(posedge mclk_in)
    begin
        gap_q  <= rst_n_in ? gap_d : 0;
        seen_q <= rst_n_in & seen_d;
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    tick_period_a: assert property (interval_tick_out && seen_q |-> gap_q == DIV_CYC - 1)
        else $error("interval tick spacing wrong");
    remote_steady_a: assert property (!$past(interval_tick_out) |-> $stable(remote_switch_bit_out))
        else $error("remote bits moved off an interval boundary");
    remote_rise_a: assert property ($past(interval_tick_out) |->
        remote_rise_out == (remote_switch_bit_out & ~$past(remote_switch_bit_out)))
        else $error("remote rising edge wrong");
    remote_fall_a: assert property ($past(interval_tick_out) |->
        remote_fall_out == (~remote_switch_bit_out & $past(remote_switch_bit_out)))
        else $error("remote falling edge wrong");
    // toggle steering is left out: its own priority against clear is open
    clear_wins_a: assert property (interval_tick_out && !nv_restore_valid_in &&
        latch_toggle_in == 16'h0000 |=>
        (latching_switch_bit_out & $past(latch_clear_condition_in)) == 16'h0000 &&
        (~latching_switch_bit_out & $past(latch_set_condition_in & ~latch_clear_condition_in))
        == 16'h0000)
        else $error("latch set or clear not applied");
    latch_hold_a: assert property (!$past(interval_tick_out) && !$past(nv_restore_valid_in)
        |-> $stable(latching_switch_bit_out))
        else $error("latch bits moved without cause");
    latch_rise_a: assert property ($past(interval_tick_out) && !$past(nv_restore_valid_in) |->
        latch_rise_out == (latching_switch_bit_out & ~$past(latching_switch_bit_out)))
        else $error("latch rising edge wrong");
    restore_load_a: assert property (nv_restore_valid_in |=>
        latching_switch_bit_out == $past(nv_restore_data_in) && !latch_changed_out)
        else $error("stored latch state not restored");
    store_pulse_a: assert property (latch_changed_out |-> $past(interval_tick_out) &&
        latch_state_out != $past(latch_state_out) ##1 !latch_changed_out)
        else $error("store request pulse wrong");
endmodule : rlcb_top_monitor

bind rlcb_top rlcb_top_monitor #(.DIV_CYC(DIV_CYC)) u_mon
(
    .mclk_in, .rst_n_in, .latch_set_condition_in, .latch_clear_condition_in,
    .latch_toggle_in, .nv_restore_valid_in, .nv_restore_data_in,
    .remote_switch_bit_out, .remote_rise_out, .remote_fall_out,
    .latching_switch_bit_out, .latch_rise_out, .latch_changed_out,
    .latch_state_out, .interval_tick_out
);

/* File: verification/rlcb_cmd_model.sv */
/* rlcb_cmd_model: port command handler issuing remote switch commands.
   Assumes the caller enters send just after a clock edge. */
`timescale 1ns/1ps
module rlcb_cmd_model
    import rlcb_pkg::*;
(
    input  wire logic             mclk_in,                  // core clock
    output logic                  strobe_out,               // command strobe
    output logic [1:0]            op_out,                   // command code
    output logic [IDX_W-1:0]      idx_out                   // remote bit number
);
    initial
    begin
        strobe_out = 1'b0;
        op_out     = 2'h0;
        idx_out    = 4'h0;
    end

    // one-cycle strobe; fields flipped after so stale values never look valid
    task automatic send(input rlcb_op_t op, input logic [IDX_W-1:0] idx);
        @(posedge mclk_in);
        strobe_out <= 1'b1;
        op_out     <= op;
        idx_out    <= idx;
        @(posedge mclk_in);
        strobe_out <= 1'b0;
        op_out     <= ~op;
        idx_out    <= ~idx;
    endtask : send
endmodule : rlcb_cmd_model

/* File: verification/rlcb_top_tb.sv */
/* rlcb_top_tb: self-checking bench for rlcb_top with a short interval.
   Assumes the monitor is bound in and the command model drives the port. */
`timescale 1ns/1ps
module rlcb_top_tb;
    import rlcb_pkg::*;
    localparam int unsigned DIV = 8;                        // short interval
    logic        mclk_in, rst_n;                            // clock, reset
    logic        strobe;                                    // command port
    logic [1:0]  op;
    logic [3:0]  idx;
    logic [15:0] set_c, clr_c, tog, nv_d, rb, rr, rf, lb, lr, lf, ls;
    logic        nv_v, lc, tick;
    int          n_errors, comparisons, cyc;

    rlcb_cmd_model cmd (.mclk_in(mclk_in), .strobe_out(strobe), .op_out(op), .idx_out(idx));
    rlcb_top #(.DIV_CYC(DIV)) uut
    (
        .mclk_in(mclk_in), .rst_n_in(rst_n), .remote_control_command_in(strobe),
        .cmd_op_in(op), .cmd_index_in(idx), .latch_set_condition_in(set_c),
        .latch_clear_condition_in(clr_c), .latch_toggle_in(tog),
        .nv_restore_valid_in(nv_v), .nv_restore_data_in(nv_d),
        .remote_switch_bit_out(rb), .remote_rise_out(rr), .remote_fall_out(rf),
        .latching_switch_bit_out(lb), .latch_rise_out(lr), .latch_fall_out(lf),
        .latch_changed_out(lc), .latch_state_out(ls), .interval_tick_out(tick)
    );

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rchk(input logic [15:0] b, input logic [15:0] r, input logic [15:0] f);
        chk("remote_bits", b, rb);
        chk("remote_rise", r, rr);
        chk("remote_fall", f, rf);
    endtask : rchk

    task automatic lchk(input logic [15:0] b, input logic [15:0] r, input logic c);
        chk("latch_bits", b, lb);
        chk("latch_rise", r, lr);
        chk("latch_changed", {15'h0000, c}, {15'h0000, lc});
        chk("latch_state", b, ls);
    endtask : lchk

    // returns one cycle after a tick, when the interval's new values stand
    task automatic next_iv;
        int n;
        n = 0;
        @(posedge mclk_in);
        #1;
        while (tick !== 1'b1 && n < 20)
        begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        if (n >= 20)
        begin
            n_errors++;
            $display("MISMATCH interval_tick expected 1 seen 0");
        end
        @(posedge mclk_in);
        #1;
    endtask : next_iv

    task automatic cond(input logic [15:0] s, input logic [15:0] c);
        @(posedge mclk_in);
        set_c <= s;
        clr_c <= c;
    endtask : cond

    task automatic t_remote;
        next_iv;
        cmd.send(RLCB_OP_ON, 4'h5);
        cmd.send(RLCB_OP_ON, 4'hF);
        next_iv;
        rchk(16'h8020, 16'h8020, 16'h0000);
        cmd.send(RLCB_OP_PULSE, 4'h3);
        cmd.send(RLCB_OP_NONE, 4'h9);
        next_iv;
        rchk(16'h8028, 16'h0008, 16'h0000);
        next_iv;
        rchk(16'h8020, 16'h0000, 16'h0008);
        cmd.send(RLCB_OP_PULSE, 4'h5);
        next_iv;
        rchk(16'h8020, 16'h0000, 16'h0000);
        next_iv;
        rchk(16'h8000, 16'h0000, 16'h0020);
        cmd.send(RLCB_OP_ON, 4'h0);
        cmd.send(RLCB_OP_OFF, 4'h0);
        cmd.send(RLCB_OP_OFF, 4'hF);
        next_iv;
        rchk(16'h0000, 16'h0000, 16'h8000);
        $display("test remote done");
    endtask : t_remote

    task automatic t_latch;
        next_iv;
        cond(16'h0003, 16'h0002);
        next_iv;
        lchk(16'h0001, 16'h0001, 1'b1);
        cond(16'h0000, 16'h0000);
        next_iv;
        lchk(16'h0001, 16'h0000, 1'b0);
        cond(16'h0001, 16'h0001);
        next_iv;
        lchk(16'h0000, 16'h0000, 1'b1);
        chk("latch_fall", 16'h0001, lf);
        cond(16'h0000, 16'h0000);
        $display("test latch done");
    endtask : t_latch

    // a long-held toggle input must flip the latch once only
    task automatic t_toggle;
        @(posedge mclk_in);
        tog <= 16'h0010;
        repeat (4) next_iv;
        chk("latch_bits", 16'h0010, lb);
        @(posedge mclk_in);
        tog <= 16'h0000;
        repeat (3) next_iv;
        chk("latch_bits", 16'h0010, lb);
        @(posedge mclk_in);
        tog <= 16'h0010;
        repeat (4) next_iv;
        chk("latch_bits", 16'h0000, lb);
        @(posedge mclk_in);
        tog <= 16'h0000;
        repeat (3) next_iv;
        $display("test toggle done");
    endtask : t_toggle

    task automatic t_restore;
        next_iv;
        @(posedge mclk_in);
        nv_v <= 1'b1;
        nv_d <= 16'hA5C3;
        @(posedge mclk_in);
        nv_v <= 1'b0;
        #1;
        lchk(16'hA5C3, 16'h0000, 1'b0);
        next_iv;
        chk("latch_bits", 16'hA5C3, lb);
        $display("test restore done");
    endtask : t_restore

    // a second power-up must drop a remote bit that was ON
    task automatic t_reset;
        cmd.send(RLCB_OP_ON, 4'h7);
        next_iv;
        rchk(16'h0080, 16'h0080, 16'h0000);
        @(posedge mclk_in);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n <= 1'b1;
        #1;
        rchk(16'h0000, 16'h0000, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            stop_test;
        end
    end

    initial
    begin
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        rst_n = 1'b0;
        {set_c, clr_c, tog, nv_d} = 64'h0;
        nv_v = 1'b0;
        repeat (5) @(posedge mclk_in);
        rst_n <= 1'b1;
        #1;
        rchk(16'h0000, 16'h0000, 16'h0000);
        t_remote;
        t_latch;
        t_toggle;
        t_restore;
        t_reset;
        stop_test;
    end
endmodule : rlcb_top_tb
